/* File: core/tlic_pkg.sv */
// package for the two-level interrupt controller: constants and carrier types
package tlic_pkg;

  localparam int unsigned VEC_W          = 21;
  localparam logic [20:0] VEC_HIGH       = 21'h00_0008;
  localparam logic [20:0] VEC_LOW        = 21'h00_0018;
  localparam int unsigned SYNC_STAGES    = 2;
  // take-to-vector latency in instruction cycles after the flag is seen
  localparam int unsigned TAKE_DELAY     = 2;
  localparam logic        PRIO_EN_RESET  = 1'b0;
  localparam logic        GIE_RESET      = 1'b0;
  localparam logic        PERIPHERAL_GROUP_ENABLE_RESET     = 1'b0;
  // bit positions of the global enables inside the control byte
  localparam int unsigned BIT_GIE_HIGH   = 7;
  localparam int unsigned BIT_GIE_LOW    = 6;

  typedef enum logic [1:0] {
    TLIC_IDLE  = 2'b00,
    TLIC_LOW   = 2'b01,
    TLIC_BOTH  = 2'b11,
    TLIC_HIGH  = 2'b10
  } tlic_state_t;

  // request to the core: take an interrupt at this vector
  typedef struct packed {
    logic             take;
    logic             high;
    logic [VEC_W-1:0] vector;
  } tlic_req_t;

  // software write of the global enables
  typedef struct packed {
    logic wr;
    logic high_level_global_enable;
    logic low_level_global_enable;
  } tlic_gie_wr_t;

endpackage : tlic_pkg

/* File: core/tlic_sync.sv */
// two-flop synchroniser bank for pin-level event inputs
`timescale 1ns/1ns
`default_nettype none
module tlic_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule // tlic_sync
`default_nettype wire

/* File: core/tlic_flags.sv */
// sticky per-source flag bank: set wins over clear
`timescale 1ns/1ns
`default_nettype none
module tlic_flags #(
  parameter int unsigned N = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] clear_i,
  output logic      [N-1:0] flag_o
);
  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      always_comb begin
        // events land whatever the enables say
        flag_next[g] = event_i[g] | (flag_reg[g] & ~clear_i[g]);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule // tlic_flags
`default_nettype wire

/* File: core/tlic_ctrl.sv */
// two-level prioritized interrupt controller core
`timescale 1ns/1ns
`default_nettype none
// Function
// - high vector 0008h, low vector 0018h
// - high request preempts running low routine
// - each source has flag, enable, priority
// - two levels only when priority enable set
// - bit 7 gates high, bit 6 gates low
// - flag, enable, global set: vector request after two instruction cycles
// - priority enable resets clear, compatibility mode
// - compatibility: bit 6 peripherals, bit 7 all
// - compatibility: every interrupt goes to 0008h
// - clear governing global enable on taking
// - hold low requests during high service
// - core pushes return, loads vector address
// - return instruction sets the cleared enable
// - pin latency three to four cycles
// - flags set regardless of any enable
// - high global clear disables all interrupts
module tlic_ctrl #(
  parameter int unsigned N_PIN  = 2,
  parameter int unsigned N_PERI = 6
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      instr_cycle_i,
  input  wire logic [N_PIN-1:0]          pin_event_i,
  input  wire logic [N_PERI-1:0]         peri_event_i,
  input  wire logic [N_PIN+N_PERI-1:0]   flag_clear_i,
  input  wire logic [N_PIN+N_PERI-1:0]   source_enable_i,
  input  wire logic [N_PIN+N_PERI-1:0]   source_priority_i,
  input  wire logic                      prio_wr_i,
  input  wire logic                      priority_levels_enable_i,
  input  wire tlic_pkg::tlic_gie_wr_t    gie_wr_i,
  input  wire logic                      take_ack_i,
  input  wire logic                      return_from_interrupt_instr_i,
  output tlic_pkg::tlic_req_t            req_o,
  output logic [N_PIN+N_PERI-1:0]        flag_o,
  output logic                           priority_levels_enable_o,
  output logic                           high_level_global_enable_o,
  output logic                           low_level_global_enable_o,
  output logic [1:0]                     service_level_o
);
  localparam int unsigned N = N_PIN + N_PERI;

  logic [N_PIN-1:0]   pin_sync;
  logic [N-1:0]       flags;
  logic [N-1:0]       pin_mask;
  logic               prio_reg;
  logic               prio_next;
  logic               high_level_global_enable_reg;
  logic               high_level_global_enable_next;
  logic               low_level_global_enable_reg;
  logic               low_level_global_enable_next;
  tlic_pkg::tlic_state_t st_reg;
  tlic_pkg::tlic_state_t st_next;
  tlic_pkg::tlic_req_t   req_reg;
  tlic_pkg::tlic_req_t   req_next;
  logic [1:0]         dly_reg;
  logic [1:0]         dly_next;
  logic               want_high;
  logic               want_low;
  logic               want_any;
  logic [N-1:0]       active;

  // pins cross into the ref_clk_i domain before being flagged
  tlic_sync #(.W(N_PIN)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (pin_event_i),
    .sync_o    (pin_sync)
  );

  tlic_flags #(.N(N)) u_flags (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .event_i   ({peri_event_i, pin_sync}),
    .clear_i   (flag_clear_i),
    .flag_o    (flags)
  );

  assign pin_mask = {{N_PERI{1'b0}}, {N_PIN{1'b1}}};

  always_comb begin
    active    = flags & source_enable_i;
    want_high = 1'b0;
    want_low  = 1'b0;
    if (prio_reg) begin
      // high enable also gates low ones
      want_high = high_level_global_enable_reg && |(active & source_priority_i);
      want_low  = high_level_global_enable_reg && low_level_global_enable_reg && |(active & ~source_priority_i);
    end else begin
      // priority bits ignored; peripherals also need the group enable
      want_high = high_level_global_enable_reg && (|(active & pin_mask)
                  || (low_level_global_enable_reg && |(active & ~pin_mask)));
    end
    // low stays pending while high service runs
    if (st_reg == tlic_pkg::TLIC_HIGH || st_reg == tlic_pkg::TLIC_BOTH) begin
      want_low = 1'b0;
    end
    want_any = want_high | want_low;
  end

  always_comb begin
    prio_next = prio_reg;
    high_level_global_enable_next = high_level_global_enable_reg;
    low_level_global_enable_next = low_level_global_enable_reg;
    st_next   = st_reg;
    req_next  = req_reg;
    dly_next  = dly_reg;
    if (prio_wr_i) begin
      prio_next = priority_levels_enable_i;
    end
    if (gie_wr_i.wr) begin
      high_level_global_enable_next = gie_wr_i.high_level_global_enable;
      low_level_global_enable_next = gie_wr_i.low_level_global_enable;
    end
    if (return_from_interrupt_instr_i) begin
      // reopen whatever level was closed on entry, innermost first
      case (st_reg)
        tlic_pkg::TLIC_BOTH: begin
          high_level_global_enable_next = 1'b1;
          st_next   = tlic_pkg::TLIC_LOW;
        end
        tlic_pkg::TLIC_HIGH: begin
          high_level_global_enable_next = 1'b1;
          st_next   = tlic_pkg::TLIC_IDLE;
        end
        tlic_pkg::TLIC_LOW: begin
          if (prio_reg) begin
            low_level_global_enable_next = 1'b1;
          end else begin
            high_level_global_enable_next = 1'b1;
          end
          st_next = tlic_pkg::TLIC_IDLE;
        end
        default: begin
          st_next = tlic_pkg::TLIC_IDLE;
        end
      endcase
    end else if (req_reg.take) begin
      // hold the request until the core pushes and jumps
      if (take_ack_i) begin
        req_next.take = 1'b0;
        if (req_reg.high) begin
          high_level_global_enable_next = 1'b0;
          st_next   = (st_reg == tlic_pkg::TLIC_LOW) ? tlic_pkg::TLIC_BOTH
                                                     : tlic_pkg::TLIC_HIGH;
        end else begin
          low_level_global_enable_next = 1'b0;
          st_next   = tlic_pkg::TLIC_LOW;
        end
      end
    end else if (want_any && instr_cycle_i) begin
      // fixed count of instruction cycles, so one- and two-cycle
      // instructions see the same latency
      if (dly_reg == 2'(tlic_pkg::TAKE_DELAY - 1)) begin
        dly_next        = 2'h0;
        req_next.take   = 1'b1;
        req_next.high   = want_high || !prio_reg;
        // compatibility mode always uses the high vector
        req_next.vector = (want_high || !prio_reg) ? tlic_pkg::VEC_HIGH
                                                   : tlic_pkg::VEC_LOW;
      end else begin
        dly_next = dly_reg + 2'h1;
      end
    end else if (!want_any) begin
      dly_next = 2'h0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prio_reg <= tlic_pkg::PRIO_EN_RESET;
      high_level_global_enable_reg <= tlic_pkg::GIE_RESET;
      low_level_global_enable_reg <= tlic_pkg::PERIPHERAL_GROUP_ENABLE_RESET;
      st_reg   <= tlic_pkg::TLIC_IDLE;
      req_reg  <= '0;
      dly_reg  <= 2'h0;
    end else begin
      prio_reg <= prio_next;
      high_level_global_enable_reg <= high_level_global_enable_next;
      low_level_global_enable_reg <= low_level_global_enable_next;
      st_reg   <= st_next;
      req_reg  <= req_next;
      dly_reg  <= dly_next;
    end
  end

  assign req_o                      = req_reg;
  assign flag_o                     = flags;
  assign priority_levels_enable_o   = prio_reg;
  assign high_level_global_enable_o = high_level_global_enable_reg;
  assign low_level_global_enable_o  = low_level_global_enable_reg;
  assign service_level_o            = st_reg;
endmodule // tlic_ctrl
`default_nettype wire

/* File: bench/tlic_ctrl_properties.sv */
// port-level assertion checker for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tlic_ctrl_checker #(
  parameter int unsigned N_PIN  = 2,
  parameter int unsigned N_PERI = 6
) (
  input wire logic                   ref_clk_i,
  input wire logic                   rst_i,
  input wire logic [N_PERI-1:0]      peri_event_i,
  input wire tlic_pkg::tlic_gie_wr_t gie_wr_i,
  input wire logic                   take_ack_i,
  input wire logic                   return_from_interrupt_instr_i,
  input wire tlic_pkg::tlic_req_t    req_o,
  input wire logic [N_PIN+N_PERI-1:0] flag_o,
  input wire logic                   priority_levels_enable_o,
  input wire logic                   high_level_global_enable_o,
  input wire logic                   low_level_global_enable_o,
  input wire logic [1:0]             service_level_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  vec_high_a: assert property (
    req_o.take && req_o.high |-> req_o.vector == tlic_pkg::VEC_HIGH) else $error("bad high vector");
  vec_low_a: assert property (
    req_o.take && !req_o.high && priority_levels_enable_o |-> req_o.vector == tlic_pkg::VEC_LOW)
    else $error("bad low vector");
  compat_vec_a: assert property (
    req_o.take && !priority_levels_enable_o |-> req_o.vector == tlic_pkg::VEC_HIGH)
    else $error("bad single vector");
  clear_high_a: assert property (
    req_o.take && take_ack_i && !return_from_interrupt_instr_i
    && (req_o.high || !priority_levels_enable_o) |=> !high_level_global_enable_o && !req_o.take)
    else $error("high enable not cleared");
  clear_low_a: assert property (
    req_o.take && take_ack_i && !return_from_interrupt_instr_i && !req_o.high
    && priority_levels_enable_o |=> !low_level_global_enable_o) else $error("low enable kept");
  ret_high_a: assert property (
    return_from_interrupt_instr_i && !gie_wr_i.wr && (service_level_o[1] || !priority_levels_enable_o)
    |=> high_level_global_enable_o) else $error("return left high enable off");
  low_hold_a: assert property (
    service_level_o[1] && priority_levels_enable_o |-> !(req_o.take && !req_o.high))
    else $error("low taken in high service");
  high_level_global_enable_off_a: assert property (
    priority_levels_enable_o && !high_level_global_enable_o && !req_o.take |=> !req_o.take)
    else $error("take with high enable off");
  flag_set_a: assert property (
    |peri_event_i |=> (flag_o[N_PIN+N_PERI-1:N_PIN] & $past(peri_event_i)) == $past(peri_event_i))
    else $error("flag not set by event");
  reset_state_a: assert property (
    $fell(rst_i) |-> !priority_levels_enable_o && !req_o.take && !high_level_global_enable_o)
    else $error("bad state after reset");
endmodule // tlic_ctrl_checker
bind tlic_ctrl tlic_ctrl_checker #(.N_PIN(N_PIN), .N_PERI(N_PERI)) u_tlic_ctrl_checker (
  .ref_clk_i, .rst_i, .peri_event_i, .gie_wr_i, .take_ack_i, .return_from_interrupt_instr_i,
  .req_o, .flag_o, .priority_levels_enable_o, .high_level_global_enable_o,
  .low_level_global_enable_o, .service_level_o);
`default_nettype wire

/* File: bench/tlic_core_model.sv */
// behavioural core: acknowledges vector requests and issues returns
`timescale 1ns/1ns
`default_nettype none
module tlic_core_model (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                slow_i,
  input  wire logic                ret_go_i,
  input  wire tlic_pkg::tlic_req_t req_i,
  output logic                     take_ack_o,
  output logic                     return_from_interrupt_instr_o
);
  logic [1:0] wait_reg;
  // a slow core stalls three cycles before pushing and jumping
  always_ff @(posedge ref_clk_i) begin
    take_ack_o <= 1'b0;
    return_from_interrupt_instr_o <= ret_go_i;
    if (rst_i) begin
      wait_reg <= 2'h0;
    end else if (req_i.take && !take_ack_o) begin
      wait_reg <= wait_reg + 2'h1;
      if (!slow_i || wait_reg == 2'h3) begin
        take_ack_o <= 1'b1;
        wait_reg <= 2'h0;
      end
    end
  end
endmodule // tlic_core_model
`default_nettype wire

/* File: bench/test_two_level_interrupt_controller.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module test_two_level_interrupt_controller;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, ret_go = 1'b0, prio_wr = 1'b0;
  logic prio_in = 1'b0, ack, ret, prio_o, gie_h, gie_l;
  logic [5:0] peri_ev = '0;
  logic [1:0] pin_ev = '0;
  logic [7:0] clr = '0, en = '0, pri = '0, flag;
  logic [1:0] lvl;
  tlic_pkg::tlic_gie_wr_t gie_wr = '0;
  tlic_pkg::tlic_req_t req;
  int failures = 0, compares = 0;
  tlic_ctrl u_tlic_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_cycle_i(1'b1),
    .pin_event_i(pin_ev), .peri_event_i(peri_ev), .flag_clear_i(clr), .source_enable_i(en),
    .source_priority_i(pri), .prio_wr_i(prio_wr), .priority_levels_enable_i(prio_in),
    .gie_wr_i(gie_wr), .take_ack_i(ack), .return_from_interrupt_instr_i(ret), .req_o(req),
    .flag_o(flag), .priority_levels_enable_o(prio_o), .high_level_global_enable_o(gie_h),
    .low_level_global_enable_o(gie_l), .service_level_o(lvl));
  tlic_core_model u_tlic_core_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow),
    .ret_go_i(ret_go), .req_i(req), .take_ack_o(ack), .return_from_interrupt_instr_o(ret));
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task tick; @(posedge ref_clk_i); #1; endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_take(input logic want);
    int i;
    for (i = 0; i < 20 && req.take !== want; i++) tick;
    if (i == 20) begin
      chk("take wait", req.take, want);
      report_and_stop;
    end
  endtask
  task fire(input int k); peri_ev[k] = 1'b1; tick; peri_ev[k] = 1'b0; endtask
  task set_gie(input logic h, input logic l); gie_wr = '{1'b1, h, l}; tick; gie_wr = '0; endtask
  task ret_pulse; ret_go = 1'b1; tick; ret_go = 1'b0; tick; tick; endtask
  task t_reset;
    chk("prio_en", prio_o, 1'b0);
    chk("take", req.take, 1'b0);
    $display("reset test done");
  endtask
  task t_compat;
    en = 8'h04;
    set_gie(1'b1, 1'b0);
    fire(0);
    chk("flag", flag[2], 1'b1);
    repeat (5) tick;
    chk("take", req.take, 1'b0);
    set_gie(1'b1, 1'b1);
    wait_take(1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_HIGH);
    wait_take(1'b0);
    chk("gie", gie_h, 1'b0);
    clr = 8'h04;
    tick;
    clr = '0;
    ret_pulse;
    chk("gie", gie_h, 1'b1);
    $display("compat test done");
  endtask
  task t_prio;
    prio_in = 1'b1; prio_wr = 1'b1; tick; prio_wr = 1'b0;
    chk("prio_en", prio_o, 1'b1);
    pri = 8'h08; en = 8'h0c; slow = 1'b1;
    set_gie(1'b1, 1'b1);
    fire(0);
    wait_take(1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_LOW);
    chk("high", req.high, 1'b0);
    wait_take(1'b0);
    chk("gie_low", gie_l, 1'b0);
    fire(1);
    wait_take(1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_HIGH);
    wait_take(1'b0);
    chk("level", lvl, 2'h3);
    fire(0);
    repeat (5) tick;
    chk("take", req.take, 1'b0);
    // flags go before any return, or the open level vectors again
    clr = 8'h0c;
    tick;
    clr = '0;
    ret_pulse;
    chk("level", lvl, 2'h1);
    chk("gie_high", gie_h, 1'b1);
    ret_pulse;
    chk("gie_low", gie_l, 1'b1);
    $display("priority test done");
  endtask
  task t_pin;
    int n;
    en = 8'h01;
    set_gie(1'b1, 1'b0);
    pin_ev[0] = 1'b1;
    tick;
    pin_ev[0] = 1'b0;
    for (n = 1; n < 10 && req.take !== 1'b1; n++) tick;
    // counted from the edge that first samples the pin to the launching edge
    chk("pin latency", (n - 1 >= 3) && (n - 1 <= 4), 1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_HIGH);
    wait_take(1'b0);
    chk("gie", gie_h, 1'b0);
    clr = 8'h01;
    tick;
    clr = '0;
    ret_pulse;
    chk("gie", gie_h, 1'b1);
    $display("pin test done");
  endtask
  task t_hold;
    fire(1);
    wait_take(1'b1);
    chk("high", req.high, 1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_HIGH);
    wait_take(1'b0);
    chk("level", lvl, 2'h2);
    chk("gie_high", gie_h, 1'b0);
    chk("gie_low", gie_l, 1'b1);
    clr = 8'h08;
    tick;
    clr = '0;
    // both globals open again, so only the service level can hold the low one off
    set_gie(1'b1, 1'b1);
    fire(0);
    repeat (5) tick;
    chk("take", req.take, 1'b0);
    ret_pulse;
    wait_take(1'b1);
    chk("vector", req.vector, tlic_pkg::VEC_LOW);
    wait_take(1'b0);
    chk("level", lvl, 2'h1);
    clr = 8'h04;
    tick;
    clr = '0;
    ret_pulse;
    chk("level", lvl, 2'h0);
    chk("gie_low", gie_l, 1'b1);
    set_gie(1'b0, 1'b1);
    fire(0);
    repeat (5) tick;
    chk("take", req.take, 1'b0);
    clr = 8'h04;
    tick;
    clr = '0;
    $display("hold test done");
  endtask
  initial begin
    repeat (20) tick;
    rst_i = 1'b0;
    tick;
    t_reset;
    t_compat;
    t_pin;
    t_prio;
    t_hold;
    report_and_stop;
  end
endmodule // test_two_level_interrupt_controller
`default_nettype wire
